// ---- hw/dtcr_top.sv ----
// Terminal configuration register bank with Avalon-MM slave.
//
// Functional notes
// - Five input function codes plus a second-motor set; only listed codes.
// - Polarity 0 normally open, 1 normally closed; inputs, output, alarm.
// - Output and alarm function codes accept 0 to 10 and 43.
// - Low-load mode: 0 off, 1 all phases, 2 constant speed only.
// - Low-load threshold 0 to 20000 in 0.01 percent steps.
// - Overload threshold 0 to 20000, separate copy for second motor.
// - Arrival thresholds for accel and decel, 0 to 4000 in 0.1 Hz.
//
// Our own choice: register access over Avalon-MM.
module dtcr_top
  import dtcr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [15:0]         avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [4:0]          term_in_pin,
  input  wire logic                motor2_sel,
  input  wire logic                out_request,
  input  wire logic                alarm_request,
  input  wire logic                running,
  input  wire logic                accelerating,
  input  wire logic                decelerating,
  input  wire dtcr_pkg::dtcr_word_t out_current,
  input  wire dtcr_pkg::dtcr_word_t out_freq,
  output logic      [4:0]          term_active,
  output dtcr_pkg::dtcr_word_t     term_function [5],
  output dtcr_pkg::dtcr_word_t     out_function,
  output dtcr_pkg::dtcr_word_t     alarm_function,
  output logic                     analog_monitor_output_sel,
  output logic                     out_pin,
  output logic                     alarm_pin,
  output logic                     low_load_flag,
  output logic                     overload_flag,
  output logic                     arrival_flag
);
  import dtcr_pkg::*;
`include "dtcr_regs.svh"

  // --------------------------------------------------------------
  // Register table
  // --------------------------------------------------------------

  localparam int NREG = 26;

  localparam logic [13:0] REG_IDX [NREG] = '{
    `DTCR_IDX_IN1_FUNC, `DTCR_IDX_IN2_FUNC, `DTCR_IDX_IN3_FUNC,
    `DTCR_IDX_IN4_FUNC, `DTCR_IDX_IN5_FUNC,
    `DTCR_IDX_IN1_POL, `DTCR_IDX_IN2_POL, `DTCR_IDX_IN3_POL,
    `DTCR_IDX_IN4_POL, `DTCR_IDX_IN5_POL,
    `DTCR_IDX_OUT_FUNC, `DTCR_IDX_ALM_FUNC, `DTCR_IDX_MON_SRC,
    `DTCR_IDX_OUT_POL, `DTCR_IDX_ALM_POL, `DTCR_IDX_OVL_THR,
    `DTCR_IDX_ARR_ACC, `DTCR_IDX_ARR_DEC, `DTCR_IDX_LL_MODE,
    `DTCR_IDX_LL_THR,
    `DTCR_IDX_IN1_FUNC2, `DTCR_IDX_IN2_FUNC2, `DTCR_IDX_IN3_FUNC2,
    `DTCR_IDX_IN4_FUNC2, `DTCR_IDX_IN5_FUNC2, `DTCR_IDX_OVL_THR2
  };

  localparam dtcr_kind_e REG_KIND [NREG] = '{
    DTCR_K_IN_FUNC, DTCR_K_IN_FUNC, DTCR_K_IN_FUNC,
    DTCR_K_IN_FUNC, DTCR_K_IN_FUNC,
    DTCR_K_BINARY, DTCR_K_BINARY, DTCR_K_BINARY,
    DTCR_K_BINARY, DTCR_K_BINARY,
    DTCR_K_OUT_FUNC, DTCR_K_OUT_FUNC, DTCR_K_BINARY,
    DTCR_K_BINARY, DTCR_K_BINARY, DTCR_K_CURRENT,
    DTCR_K_FREQ, DTCR_K_FREQ, DTCR_K_LL_MODE,
    DTCR_K_CURRENT,
    DTCR_K_IN_FUNC, DTCR_K_IN_FUNC, DTCR_K_IN_FUNC,
    DTCR_K_IN_FUNC, DTCR_K_IN_FUNC, DTCR_K_CURRENT
  };

  // Entry numbers used by the terminal logic.
  localparam int E_IN_FUNC  = 0;
  localparam int E_IN_POL   = 5;
  localparam int E_OUT_FUNC = 10;
  localparam int E_ALM_FUNC = 11;
  localparam int E_MON_SRC  = 12;
  localparam int E_OUT_POL  = 13;
  localparam int E_ALM_POL  = 14;
  localparam int E_OVL_THR  = 15;
  localparam int E_ARR_ACC  = 16;
  localparam int E_ARR_DEC  = 17;
  localparam int E_LL_MODE  = 18;
  localparam int E_LL_THR   = 19;
  localparam int E_IN_FUNC2 = 20;
  localparam int E_OVL_THR2 = 25;

  dtcr_word_t      regs [NREG];
  logic [NREG-1:0] hit;
  logic            status_hit;
  logic [13:0]     word_idx;
  dtcr_word_t      sel_value;
  dtcr_kind_e      sel_kind;
  dtcr_word_t      merged;
  logic            value_ok;
  logic [31:0]     next_readdata;
  dtcr_bus_e       bus_state;
  logic            write_now;
  logic [4:0]      pin_meta;
  logic [4:0]      pin_sync;

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------

  assign word_idx = avs_address[15:2];

  // Compare the word index against every entry of the table.
  always_comb
  begin
    hit = '0;
    for (int i = 0; i < NREG; i++)
    begin
      hit[i] = (word_idx == REG_IDX[i]);
    end
    status_hit = (word_idx == `DTCR_IDX_STATUS);
  end

  // Select the addressed entry and its value class.
  always_comb
  begin
    sel_value = '0;
    sel_kind  = DTCR_K_IN_FUNC;
    for (int i = 0; i < NREG; i++)
    begin
      if (hit[i])
      begin
        sel_value = regs[i];
        sel_kind  = REG_KIND[i];
      end
    end
  end

  // Unwritten byte lanes keep the stored bits; upper lanes are ignored.
  assign merged = {avs_byteenable[1] ? avs_writedata[15:8] : sel_value[15:8],
                   avs_byteenable[0] ? avs_writedata[7:0]  : sel_value[7:0]};

  // The merged value is checked before it may be stored.
  dtcr_code_check u_check
  (
    .kind  (sel_kind),
    .value (merged),
    .ok    (value_ok)
  );

  // --------------------------------------------------------------
  // Avalon-MM answer
  // --------------------------------------------------------------

  // One wait state per access keeps the decode and check off the
  // critical path at the cost of half the peak bus rate.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_state <= DTCR_IDLE;
    end
    else
    begin
      case (bus_state)
        DTCR_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_state <= DTCR_ANSWER;
          end
        end
        DTCR_ANSWER: bus_state <= DTCR_IDLE;
        default:     bus_state <= DTCR_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) &&
                           (bus_state != DTCR_ANSWER);
  assign write_now = avs_write && (bus_state == DTCR_ANSWER) &&
                     (|hit) && value_ok;

  // Read data: table entries, the status word, or zero when unmapped.
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (|hit)
    begin
      next_readdata = {16'h0000, sel_value};
    end
    else if (status_hit)
    begin
      next_readdata = {19'h0_0000, arrival_flag, overload_flag,
                       low_load_flag, term_active, pin_sync};
    end
  end

  // Read data is captured on the first cycle and stands afterwards.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && (bus_state == DTCR_IDLE))
    begin
      avs_readdata <= next_readdata;
    end
  end

  // --------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------

  // Each entry only ever holds a value its class accepts.
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        regs[g] <= `DTCR_RST_VALUE;
      end
      else if (write_now && hit[g])
      begin
        regs[g] <= merged;
      end
    end
  end

  // --------------------------------------------------------------
  // Terminal logic
  // --------------------------------------------------------------

  // Pins are asynchronous to clk, so two flops come first.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= term_in_pin;
      pin_sync <= pin_meta;
    end
  end

  // Per-terminal level conversion and function selection.
  for (genvar t = 0; t < 5; t++)
  begin : g_term
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        term_active[t]   <= 1'b0;
        term_function[t] <= `DTCR_RST_VALUE;
      end
      else
      begin
        term_active[t] <= pin_sync[t] ^
                          regs[E_IN_POL + t][`DTCR_POL_BIT];
        term_function[t] <= motor2_sel ? regs[E_IN_FUNC2 + t]
                                       : regs[E_IN_FUNC + t];
      end
    end
  end

  // Output side: function codes, monitor source and pin polarity.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      out_function              <= `DTCR_RST_VALUE;
      alarm_function            <= `DTCR_RST_VALUE;
      analog_monitor_output_sel <= 1'b0;
      out_pin                   <= 1'b0;
      alarm_pin                 <= 1'b0;
    end
    else
    begin
      out_function   <= regs[E_OUT_FUNC];
      alarm_function <= regs[E_ALM_FUNC];
      analog_monitor_output_sel <= regs[E_MON_SRC][0];
      out_pin   <= out_request ^ regs[E_OUT_POL][`DTCR_POL_BIT];
      alarm_pin <= alarm_request ^ regs[E_ALM_POL][`DTCR_POL_BIT];
    end
  end

  // Low-load detection; mode 2 holds the flag low during the ramps.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      low_load_flag <= 1'b0;
    end
    else if (regs[E_LL_MODE] == `DTCR_LL_OFF)
    begin
      low_load_flag <= 1'b0;
    end
    else if ((regs[E_LL_MODE] == `DTCR_LL_ALL_PHASES) ||
             (!accelerating && !decelerating))
    begin
      low_load_flag <= running && (out_current < regs[E_LL_THR]);
    end
    else
    begin
      low_load_flag <= 1'b0;
    end
  end

  // Overload signal uses the copy of the motor in service.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      overload_flag <= 1'b0;
    end
    else
    begin
      overload_flag <= out_current > (motor2_sel ? regs[E_OVL_THR2]
                                                 : regs[E_OVL_THR]);
    end
  end

  // Arrival compares only while a ramp is under way.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arrival_flag <= 1'b0;
    end
    else if (accelerating)
    begin
      arrival_flag <= out_freq >= regs[E_ARR_ACC];
    end
    else if (decelerating)
    begin
      arrival_flag <= out_freq <= regs[E_ARR_DEC];
    end
    else
    begin
      arrival_flag <= 1'b0;
    end
  end

endmodule : dtcr_top

// ---- include/dtcr_regs.svh ----
// Register indices, reset values and field limits of the terminal bank.
`ifndef DTCR_REGS_SVH
`define DTCR_REGS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define DTCR_IDX_IN1_FUNC      14'h1103
`define DTCR_IDX_IN2_FUNC      14'h1104
`define DTCR_IDX_IN3_FUNC      14'h1105
`define DTCR_IDX_IN4_FUNC      14'h1106
`define DTCR_IDX_IN5_FUNC      14'h1107
`define DTCR_IDX_IN1_POL       14'h110b
`define DTCR_IDX_IN2_POL       14'h110c
`define DTCR_IDX_IN3_POL       14'h110d
`define DTCR_IDX_IN4_POL       14'h110e
`define DTCR_IDX_IN5_POL       14'h110f
`define DTCR_IDX_OUT_FUNC      14'h1114
`define DTCR_IDX_ALM_FUNC      14'h1119
`define DTCR_IDX_MON_SRC       14'h111b
`define DTCR_IDX_OUT_POL       14'h111d
`define DTCR_IDX_ALM_POL       14'h1122
`define DTCR_IDX_OVL_THR       14'h1124
`define DTCR_IDX_ARR_ACC       14'h1126
`define DTCR_IDX_ARR_DEC       14'h1128
`define DTCR_IDX_LL_MODE       14'h1178
`define DTCR_IDX_LL_THR        14'h1179
`define DTCR_IDX_IN1_FUNC2     14'h1532
`define DTCR_IDX_IN2_FUNC2     14'h1533
`define DTCR_IDX_IN3_FUNC2     14'h1534
`define DTCR_IDX_IN4_FUNC2     14'h1535
`define DTCR_IDX_IN5_FUNC2     14'h1536
`define DTCR_IDX_OVL_THR2      14'h153a
`define DTCR_IDX_STATUS        14'h1200

// ------------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------------
`define DTCR_RST_VALUE         16'h0000
`define DTCR_MAX_CURRENT       16'h4e20
`define DTCR_MAX_FREQ          16'h0fa0
`define DTCR_MAX_OUT_CODE      16'h000a
`define DTCR_OUT_CODE_EXTRA    16'h002b
`define DTCR_MAX_LL_MODE       16'h0002
`define DTCR_LL_OFF            16'h0000
`define DTCR_LL_ALL_PHASES     16'h0001
`define DTCR_POL_BIT           0

`endif

// ---- include/dtcr_pkg.sv ----
// Types shared by the terminal configuration bank.
package dtcr_pkg;

  // Value classes, each with its own set of accepted codes.
  typedef enum logic [2:0]
  {
    DTCR_K_IN_FUNC  = 3'h0,
    DTCR_K_OUT_FUNC = 3'h1,
    DTCR_K_BINARY   = 3'h2,
    DTCR_K_LL_MODE  = 3'h3,
    DTCR_K_CURRENT  = 3'h4,
    DTCR_K_FREQ     = 3'h5
  } dtcr_kind_e;

  // Bus answer states.
  typedef enum logic [1:0]
  {
    DTCR_IDLE   = 2'b01,
    DTCR_ANSWER = 2'b10
  } dtcr_bus_e;

  typedef logic [15:0] dtcr_word_t;

endpackage : dtcr_pkg

// ---- hw/dtcr_code_check.sv ----
// Accept or refuse a register value according to its value class.
module dtcr_code_check
  import dtcr_pkg::*;
(
  input  dtcr_pkg::dtcr_kind_e kind,
  input  dtcr_pkg::dtcr_word_t value,
  output logic                 ok
);
`include "dtcr_regs.svh"

  // --------------------------------------------------------------
  // Code lists
  // --------------------------------------------------------------

  // Input function codes form a sparse list, so they are spelled out.
  function automatic logic in_code_ok(input dtcr_word_t v);
    case (v)
      16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
      16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000b, 16'h000c,
      16'h000d, 16'h000f, 16'h0010, 16'h0012, 16'h0013, 16'h0014,
      16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h001b, 16'h001c,
      16'h001d, 16'h001f, 16'h0032, 16'h0033, 16'h0034, 16'h0035,
      16'h0040, 16'h00ff: in_code_ok = 1'b1;
      default:            in_code_ok = 1'b0;
    endcase
  endfunction : in_code_ok

  // Range test per class; any class not listed is refused.
  always_comb
  begin
    case (kind)
      DTCR_K_IN_FUNC:  ok = in_code_ok(value);
      DTCR_K_OUT_FUNC: ok = (value <= `DTCR_MAX_OUT_CODE) ||
                            (value == `DTCR_OUT_CODE_EXTRA);
      DTCR_K_BINARY:   ok = (value <= 16'h0001);
      DTCR_K_LL_MODE:  ok = (value <= `DTCR_MAX_LL_MODE);
      DTCR_K_CURRENT:  ok = (value <= `DTCR_MAX_CURRENT);
      DTCR_K_FREQ:     ok = (value <= `DTCR_MAX_FREQ);
      default:         ok = 1'b0;
    endcase
  end

endmodule : dtcr_code_check

// ---- tb/dtcr_checker.sv ----
// Concurrent checks on the ports of the terminal configuration bank.
`include "dtcr_regs.svh"
module dtcr_checker
  import dtcr_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 srst,
  input wire logic [15:0]          avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic                 out_request,
  input wire logic [4:0]           term_active,
  input wire dtcr_pkg::dtcr_word_t out_function,
  input wire logic                 out_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic        done_wr;
  logic        out_wr;
  logic [15:0] last_wdata;
  // A write is taken at the edge where waitrequest is seen low.
  assign done_wr = avs_write && !avs_waitrequest;
  assign out_wr  = done_wr && avs_byteenable[1:0] == 2'b11 &&
                   avs_address[15:2] == `DTCR_IDX_OUT_FUNC;
  // The copy check needs the word of the last taken write.
  always_ff @(posedge clk)
    if (done_wr)
      last_wdata <= avs_writedata[15:0];
  req_wait_a: assert property
    ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered without a wait state");
  one_wait_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited longer than one cycle");
  upper_zero_a: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read data lanes not zero");
  rd_stand_a: assert property
    (!avs_read ##1 !avs_read |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  hole_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[15:2] == 14'h0000 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  rst_clear_a: assert property (disable iff (1'b0) srst |=>
    avs_readdata == 32'h0 && term_active == 5'h0 && !out_pin)
    else $error("outputs not cleared by reset");
  out_copy_a: assert property (out_wr &&
    avs_writedata[15:0] <= 16'h000a |-> ##[1:2] out_function == last_wdata)
    else $error("legal output function code not taken");
  out_keep_a: assert property (out_wr &&
    !(avs_writedata[15:0] inside {[16'h0000:16'h000a], 16'h002b}) |=>
    $stable(out_function) [*2])
    else $error("illegal output function code changed the copy");
  out_follow_a: assert property ($changed(out_request) &&
    !$past(done_wr) && !$past(srst) |=> $changed(out_pin))
    else $error("output pin did not follow its request");
  cover property (out_wr);
  cover property (avs_read && !avs_waitrequest &&
    avs_address[15:2] == 14'h0000);
  cover property ($changed(out_request) ##1 $changed(out_pin));
endmodule : dtcr_checker

bind dtcr_top dtcr_checker u_checker (.clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .out_request, .term_active, .out_function, .out_pin);

// ---- tb/dtcr_master.sv ----
// Avalon-MM master model standing in for the network side of the bank.
module dtcr_master
(
  input  wire logic        clk,
  output logic      [15:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // The bus is idle at time zero.
  initial
  begin
    avs_address    = 16'h0000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end
  // One transfer; waitrequest and read data are taken at the rising edge
  // that answers, and the request stands unchanged until that edge.
  task automatic xfer(input logic w, input logic [13:0] i,
                      input logic [15:0] d, input logic [1:0] lanes,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address    <= {i, 2'b00};
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= {2'b00, lanes};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    // Released lines show a changed pattern, never the old request.
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : dtcr_master

// ---- tb/testbench.sv ----
// Self-checking testbench of the terminal configuration bank.
`include "dtcr_regs.svh"
module testbench;
  import dtcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, avs_read, avs_write, avs_waitrequest, out_pin, alarm_pin;
  logic srst = 1'b1, motor2_sel = 1'b0, out_request = 1'b0;
  logic alarm_request = 1'b0, running = 1'b0, accelerating = 1'b0;
  logic decelerating = 1'b0, low_load_flag, overload_flag, arrival_flag;
  logic [4:0]  term_in_pin = 5'h00, term_active;
  logic [15:0] avs_address, out_current = 16'h0000, out_freq = 16'h0000;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  dtcr_word_t  term_function [5], alarm_function;
  logic        analog_monitor_output_sel;
  int          errors, num_checks;
  // Register indices in table order and the value class of each.
  logic [13:0] idx [26] = '{14'h1103, 14'h1104, 14'h1105, 14'h1106,
    14'h1107, 14'h110b, 14'h110c, 14'h110d, 14'h110e, 14'h110f, 14'h1114,
    14'h1119, 14'h111b, 14'h111d, 14'h1122, 14'h1124, 14'h1126, 14'h1128,
    14'h1178, 14'h1179, 14'h1532, 14'h1533, 14'h1534, 14'h1535, 14'h1536,
    14'h153a};
  int kd [26] = '{0,0,0,0,0,2,2,2,2,2,1,1,2,2,2,4,5,5,3,4,0,0,0,0,0,4};
  // Highest accepted value and a just-refused value of each class.
  logic [15:0] hi [6] = '{16'h00ff, 16'h002b, 16'h0001, 16'h0002,
    16'h4e20, 16'h0fa0};
  logic [15:0] bad [6] = '{16'h00fe, 16'h000b, 16'h0002, 16'h0003,
    16'h4e21, 16'h0fa1};

  dtcr_top dut (.clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .term_in_pin, .motor2_sel, .out_request, .alarm_request, .running,
    .accelerating, .decelerating, .out_current, .out_freq, .term_active,
    .term_function, .out_function(), .alarm_function,
    .analog_monitor_output_sel, .out_pin, .alarm_pin, .low_load_flag,
    .overload_flag, .arrival_flag);
  dtcr_master bus (.clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [13:0] i, input logic [15:0] d);
    logic [31:0] q;
    bus.xfer(1'b1, i, d, 2'b11, q);
  endtask : wr
  task automatic rd_chk(input logic [13:0] i, input logic [15:0] e);
    logic [31:0] q;
    bus.xfer(1'b0, i, 16'h0000, 2'b11, q);
    chk(q, {16'h0000, e});
  endtask : rd_chk
  // Drive state inputs after an edge, then wait past the output lag.
  task automatic drive(input logic [2:0] st, input logic m2,
                       input logic [15:0] cur, input logic [15:0] f);
    @(posedge clk);
    running      <= st[2];
    accelerating <= st[1];
    decelerating <= st[0];
    motor2_sel   <= m2;
    out_current  <= cur;
    out_freq     <= f;
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask : drive

  // Reset value, then top value kept against a just-refused write.
  task automatic t_range;
    for (int n = 0; n < 26; n++)
    begin
      rd_chk(idx[n], 16'h0000);
      wr(idx[n], hi[kd[n]]);
      wr(idx[n], bad[kd[n]]);
      rd_chk(idx[n], hi[kd[n]]);
    end
  endtask : t_range
  // Every code 0..299 offered to an input and to the output function.
  task automatic t_codes;
    logic [15:0] a, b;
    a = 16'h00ff;
    b = 16'h002b;
    for (int v = 0; v < 300; v++)
    begin
      if (v inside {[0:9], 11, 12, 13, 15, 16, [18:24], [27:29], 31,
                    [50:53], 64, 255})
        a = v[15:0];
      if (v inside {[0:10], 43})
        b = v[15:0];
      wr(`DTCR_IDX_IN1_FUNC2, v[15:0]);
      rd_chk(`DTCR_IDX_IN1_FUNC2, a);
      wr(`DTCR_IDX_OUT_FUNC, v[15:0]);
      rd_chk(`DTCR_IDX_OUT_FUNC, b);
    end
  endtask : t_codes
  // Upper lane alone merges with the kept low byte; unmapped reads zero.
  task automatic t_lanes;
    logic [31:0] q;
    wr(`DTCR_IDX_LL_THR, 16'h1234);
    bus.xfer(1'b1, `DTCR_IDX_LL_THR, 16'h45ff, 2'b10, q);
    rd_chk(`DTCR_IDX_LL_THR, 16'h4534);
    bus.xfer(1'b1, `DTCR_IDX_LL_THR, 16'hff00, 2'b10, q);
    rd_chk(`DTCR_IDX_LL_THR, 16'h4534);
    wr(14'h0000, 16'h5555);
    rd_chk(14'h0000, 16'h0000);
  endtask : t_lanes
  // Polarity per terminal and the second-motor function set.
  task automatic t_pol;
    for (int n = 0; n < 5; n++)
      wr(idx[5 + n], {15'h0000, n[0]});
    wr(`DTCR_IDX_OUT_POL, 16'h0001);
    wr(`DTCR_IDX_ALM_POL, 16'h0000);
    wr(`DTCR_IDX_IN1_FUNC, 16'h0007);
    wr(`DTCR_IDX_IN1_FUNC2, 16'h0040);
    wr(`DTCR_IDX_ALM_FUNC, 16'h0005);
    wr(`DTCR_IDX_STATUS, 16'hffff);
    @(posedge clk);
    term_in_pin   <= 5'b00110;
    out_request   <= 1'b1;
    alarm_request <= 1'b1;
    drive(3'b000, 1'b0, 16'h0000, 16'h0000);
    chk({27'h0, term_active}, 32'h0000_000c);
    chk({30'h0, out_pin, alarm_pin}, 32'h1);
    chk({16'h0, term_function[0]}, 32'h0000_0007);
    chk({16'h0, term_function[4]}, 32'h0000_00ff);
    chk({16'h0, alarm_function}, 32'h0000_0005);
    chk({31'h0, analog_monitor_output_sel}, 32'h1);
    // Status word: pins 00110, active terminals 01100, flags all low.
    rd_chk(`DTCR_IDX_STATUS, 16'h0186);
    @(posedge clk);
    out_request <= 1'b0;
    drive(3'b000, 1'b1, 16'h0000, 16'h0000);
    chk({30'h0, out_pin, alarm_pin}, 32'h3);
    chk({16'h0, term_function[0]}, 32'h0000_0040);
  endtask : t_pol
  // Low-load modes, overload copies and arrival thresholds.
  task automatic t_flags;
    wr(`DTCR_IDX_LL_THR, 16'h0064);
    for (int m = 0; m < 3; m++)
    begin
      wr(`DTCR_IDX_LL_MODE, m[15:0]);
      drive(3'b110, 1'b0, 16'h0032, 16'h0000);
      chk({31'h0, low_load_flag}, {31'h0, m == 1});
    end
    drive(3'b100, 1'b0, 16'h0032, 16'h0000);
    chk({31'h0, low_load_flag}, 32'h1);
    wr(`DTCR_IDX_OVL_THR, 16'h03e8);
    wr(`DTCR_IDX_OVL_THR2, 16'h07d0);
    drive(3'b100, 1'b0, 16'h03e9, 16'h0000);
    chk({31'h0, overload_flag}, 32'h1);
    drive(3'b100, 1'b1, 16'h03e9, 16'h0000);
    chk({31'h0, overload_flag}, 32'h0);
    drive(3'b100, 1'b0, 16'h03e8, 16'h0000);
    chk({31'h0, overload_flag}, 32'h0);
    wr(`DTCR_IDX_ARR_ACC, 16'h0190);
    wr(`DTCR_IDX_ARR_DEC, 16'h012c);
    drive(3'b110, 1'b0, 16'h0000, 16'h0190);
    chk({31'h0, arrival_flag}, 32'h1);
    drive(3'b110, 1'b0, 16'h0000, 16'h018f);
    chk({31'h0, arrival_flag}, 32'h0);
    drive(3'b101, 1'b0, 16'h0000, 16'h012c);
    chk({31'h0, arrival_flag}, 32'h1);
    drive(3'b101, 1'b0, 16'h0000, 16'h012d);
    chk({31'h0, arrival_flag}, 32'h0);
  endtask : t_flags
  task automatic summarize;
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The whole run needs some 4100 cycles; 20000 means a hang.
  initial
  begin
    #1000000;
    errors++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_range();
    t_codes();
    t_lanes();
    t_pol();
    t_flags();
    summarize();
  end
endmodule : testbench
